// *** include/ais_pkg.sv ***
/*
  Shared constants and types of the power-up and initialisation sequencer:
  register offsets, field positions, reset values and timing counts.
  Assumes a 250 MHz system clock.
*/
`default_nettype none

package ais_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_KHZ          = 250000;
  localparam int unsigned INIT_DONE_MS     = 32;
  localparam int unsigned ISO_READY_MS     = 62;
  localparam int unsigned READY_PULSE_NS   = 15625;
  localparam int unsigned INIT_DONE_CYCLES = INIT_DONE_MS * CLK_KHZ;
  localparam int unsigned ISO_READY_CYCLES = ISO_READY_MS * CLK_KHZ;
  // A pulse length is a longest time, so it rounds down
  localparam int unsigned READY_PULSE_CYCLES =
    (READY_PULSE_NS * (CLK_KHZ / 1000)) / 1000;
  localparam int unsigned DELAY_W = 24;
  localparam int unsigned PULSE_W = 12;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] PRIMARY_STATUS_OFS   = 8'h00;
  localparam logic [7:0] INT_MASK_OFS         = 8'h04;
  localparam logic [7:0] SECONDARY_STATUS_OFS = 8'h08;
  localparam logic [7:0] DEVICE_CONFIG_OFS    = 8'h0c;
  localparam logic [7:0] CONFIG_LOCK_OFS      = 8'h10;
  localparam logic [7:0] ISO_ACCESS_OFS       = 8'h14;
  localparam logic [7:0] INPUT_SHORT_OFS      = 8'h18;

  // ==========================================================================
  // Field positions and values
  localparam int unsigned CONV_READY_BIT   = 4;
  localparam int unsigned INIT_DONE_BIT    = 5;
  localparam int unsigned ISO_READY_BIT    = 0;
  localparam int unsigned LOCKED_BIT       = 1;
  localparam int unsigned SHORT_ACTIVE_BIT = 2;
  localparam int unsigned CLOCK_OUT_EN_BIT = 0;
  localparam int unsigned SOFT_RESET_BIT   = 1;
  localparam int unsigned ISO_WR_EN_BIT    = 0;
  localparam int unsigned SHORT_SEL_BIT    = 0;
  localparam logic [7:0]  LOCK_KEY         = 8'hd4;
  localparam logic [7:0]  STATUS_RESET     = 8'h00;
  localparam logic [7:0]  MASK_RESET       = 8'h00;

  // Event flags held in the primary status register
  typedef struct packed {
    logic       initDone;
    logic       convReady;
  } ais_events_t;

  localparam ais_events_t EVENTS_NONE = '{initDone: 1'b0, convReady: 1'b0};

endpackage

`default_nettype wire

// *** hw/ais_delay.sv ***
/*
  Restartable one-shot delay: done rises LIMIT cycles after reset or
  restart and then stays high.
  Assumes a synchronous active-low reset.
*/
`default_nettype none

module ais_delay #(
  parameter logic [ais_pkg::DELAY_W-1:0] LIMIT = 24'h000010
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic restart,
  output var  logic done
);

  // ==========================================================================
  // Counter
  logic [ais_pkg::DELAY_W-1:0] count_reg;
  logic [ais_pkg::DELAY_W-1:0] count_next;
  logic                        done_reg;
  logic                        done_next;

  always_comb begin
    count_next = count_reg;
    done_next  = done_reg;
    if (restart) begin
      count_next = '0;
      done_next  = 1'b0;
    end else if (!done_reg) begin
      count_next = count_reg + 1'b1;
      done_next  = (count_next == LIMIT);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      count_reg <= '0;
      done_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      done_reg  <= done_next;
    end
  end

  assign done = done_reg;

endmodule

`default_nettype wire

// *** hw/ais_init_seq.sv ***
/*
  Power-up and initialisation sequencer of an isolated sigma-delta ADC
  front end, with a classic Wishbone register slave, sticky event flags,
  an interrupt and the shared clock-out / sample-ready pin.
  Assumes one 250 MHz clock, synchronous active-low reset, and a
  conversion strobe from the modulators synchronous to the clock.
*/
`default_nettype none

module ais_init_seq #(
  parameter logic [ais_pkg::DELAY_W-1:0] INIT_DONE_CYCLES =
    ais_pkg::DELAY_W'(ais_pkg::INIT_DONE_CYCLES),
  parameter logic [ais_pkg::DELAY_W-1:0] ISO_READY_CYCLES =
    ais_pkg::DELAY_W'(ais_pkg::ISO_READY_CYCLES)
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        sampleStrobe,
  output var  logic        clockOrReadyOutPin,
  output var  logic        inputShortEnable,
  output var  logic        irq,
  output var  logic        irqN
);

  // ==========================================================================
  // Start-up timers
  logic softReset_reg;
  logic softReset_next;
  logic initDoneLevel;
  logic isoReady;
  logic initDonePrev_reg;

  ais_delay #(.LIMIT(INIT_DONE_CYCLES)) initTimer (
    .clock   (clock),
    .rstn    (rstn),
    .restart (softReset_reg),
    .done    (initDoneLevel)
  );

  ais_delay #(.LIMIT(ISO_READY_CYCLES)) isoTimer (
    .clock   (clock),
    .rstn    (rstn),
    .restart (softReset_reg),
    .done    (isoReady)
  );

  // ==========================================================================
  // Bus decode
  logic        busReq;
  logic        wrStrobe;
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] rdData_reg;
  logic [31:0] rdData_next;
  logic        lowLane;

  assign busReq   = wb_cyc_i && wb_stb_i;
  assign wrStrobe = busReq && wb_we_i && ack_reg;
  assign lowLane  = wb_sel_i[0];

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction

  // ==========================================================================
  // Registers and events
  ais_pkg::ais_events_t status_reg;
  ais_pkg::ais_events_t status_next;
  ais_pkg::ais_events_t mask_reg;
  ais_pkg::ais_events_t mask_next;
  ais_pkg::ais_events_t setEv;
  ais_pkg::ais_events_t clrEv;
  logic                 locked_reg;
  logic                 locked_next;
  logic                 clkOutEn_reg;
  logic                 clkOutEn_next;
  logic                 isoWrEn_reg;
  logic                 isoWrEn_next;
  logic                 shortSel_reg;
  logic                 shortSel_next;
  logic [7:0]           statusByte;
  logic [7:0]           maskByte;
  logic [7:0]           secondaryByte;
  logic [7:0]           wrByte;

  assign wrByte = wb_dat_i[7:0];

  always_comb begin
    setEv                    = ais_pkg::EVENTS_NONE;
    setEv.initDone           = initDoneLevel && !initDonePrev_reg;
    setEv.convReady          = sampleStrobe && isoReady;
    clrEv                    = ais_pkg::EVENTS_NONE;
    if (wrStrobe && lowLane &&
        hit(wb_adr_i, ais_pkg::PRIMARY_STATUS_OFS)) begin
      clrEv.initDone  = wrByte[ais_pkg::INIT_DONE_BIT];
      clrEv.convReady = wrByte[ais_pkg::CONV_READY_BIT];
    end
  end

  always_comb begin
    // A set in the same cycle as its clear wins
    status_next   = (status_reg & ~clrEv) | setEv;
    mask_next     = mask_reg;
    locked_next   = locked_reg;
    clkOutEn_next = clkOutEn_reg;
    isoWrEn_next  = isoWrEn_reg;
    shortSel_next = shortSel_reg;
    softReset_next = 1'b0;
    if (wrStrobe && lowLane) begin
      if (hit(wb_adr_i, ais_pkg::INT_MASK_OFS)) begin
        mask_next.initDone  = wrByte[ais_pkg::INIT_DONE_BIT];
        mask_next.convReady = wrByte[ais_pkg::CONV_READY_BIT];
      end else if (hit(wb_adr_i, ais_pkg::DEVICE_CONFIG_OFS)) begin
        softReset_next = wrByte[ais_pkg::SOFT_RESET_BIT];
        if (!locked_reg) begin
          clkOutEn_next = wrByte[ais_pkg::CLOCK_OUT_EN_BIT];
        end
      end else if (hit(wb_adr_i, ais_pkg::CONFIG_LOCK_OFS)) begin
        if (wrByte == ais_pkg::LOCK_KEY) begin
          locked_next = 1'b1;
        end
      end else if (hit(wb_adr_i, ais_pkg::ISO_ACCESS_OFS)) begin
        isoWrEn_next = wrByte[ais_pkg::ISO_WR_EN_BIT];
      end else if (hit(wb_adr_i, ais_pkg::INPUT_SHORT_OFS)) begin
        if (isoWrEn_reg) begin
          shortSel_next = wrByte[ais_pkg::SHORT_SEL_BIT];
        end
      end
    end
    if (softReset_reg) begin
      status_next   = ais_pkg::EVENTS_NONE;
      mask_next     = ais_pkg::EVENTS_NONE;
      locked_next   = 1'b0;
      clkOutEn_next = 1'b0;
      isoWrEn_next  = 1'b0;
      shortSel_next = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      status_reg       <= ais_pkg::EVENTS_NONE;
      mask_reg         <= ais_pkg::EVENTS_NONE;
      locked_reg       <= 1'b0;
      clkOutEn_reg     <= 1'b0;
      isoWrEn_reg      <= 1'b0;
      shortSel_reg     <= 1'b0;
      softReset_reg    <= 1'b0;
      initDonePrev_reg <= 1'b0;
    end else begin
      status_reg       <= status_next;
      mask_reg         <= mask_next;
      locked_reg       <= locked_next;
      clkOutEn_reg     <= clkOutEn_next;
      isoWrEn_reg      <= isoWrEn_next;
      shortSel_reg     <= shortSel_next;
      softReset_reg    <= softReset_next;
      initDonePrev_reg <= initDoneLevel && !softReset_reg;
    end
  end

  // ==========================================================================
  // Read path
  always_comb begin
    statusByte                              = ais_pkg::STATUS_RESET;
    statusByte[ais_pkg::INIT_DONE_BIT]      = status_reg.initDone;
    statusByte[ais_pkg::CONV_READY_BIT]     = status_reg.convReady;
    maskByte                                = ais_pkg::MASK_RESET;
    maskByte[ais_pkg::INIT_DONE_BIT]        = mask_reg.initDone;
    maskByte[ais_pkg::CONV_READY_BIT]       = mask_reg.convReady;
    secondaryByte                           = 8'h00;
    secondaryByte[ais_pkg::ISO_READY_BIT]   = isoReady;
    secondaryByte[ais_pkg::LOCKED_BIT]      = locked_reg;
    secondaryByte[ais_pkg::SHORT_ACTIVE_BIT] = shortSel_reg;
  end

  always_comb begin
    ack_next    = busReq && !ack_reg;
    rdData_next = rdData_reg;
    if (ack_next) begin
      rdData_next = 32'h0000_0000;
      if (hit(wb_adr_i, ais_pkg::PRIMARY_STATUS_OFS)) begin
        rdData_next[7:0] = statusByte;
      end else if (hit(wb_adr_i, ais_pkg::INT_MASK_OFS)) begin
        rdData_next[7:0] = maskByte;
      end else if (hit(wb_adr_i, ais_pkg::SECONDARY_STATUS_OFS)) begin
        rdData_next[7:0] = secondaryByte;
      end else if (hit(wb_adr_i, ais_pkg::DEVICE_CONFIG_OFS)) begin
        rdData_next[ais_pkg::CLOCK_OUT_EN_BIT] = clkOutEn_reg;
      end else if (hit(wb_adr_i, ais_pkg::CONFIG_LOCK_OFS)) begin
        rdData_next[0] = locked_reg;
      end else if (hit(wb_adr_i, ais_pkg::ISO_ACCESS_OFS)) begin
        rdData_next[ais_pkg::ISO_WR_EN_BIT] = isoWrEn_reg;
      end else if (hit(wb_adr_i, ais_pkg::INPUT_SHORT_OFS)) begin
        rdData_next[ais_pkg::SHORT_SEL_BIT] = shortSel_reg;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ack_reg    <= 1'b0;
      rdData_reg <= 32'h0000_0000;
    end else begin
      ack_reg    <= ack_next;
      rdData_reg <= rdData_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdData_reg;

  // ==========================================================================
  // Clock-out / sample-ready pin
  logic [ais_pkg::PULSE_W-1:0] pulseCnt_reg;
  logic [ais_pkg::PULSE_W-1:0] pulseCnt_next;
  logic                        divClk_reg;
  logic                        pin_reg;
  logic                        pin_next;

  always_comb begin
    pulseCnt_next = pulseCnt_reg;
    if (setEv.convReady) begin
      pulseCnt_next = ais_pkg::PULSE_W'(ais_pkg::READY_PULSE_CYCLES);
    end else if (pulseCnt_reg != '0) begin
      pulseCnt_next = pulseCnt_reg - 1'b1;
    end
    if (clkOutEn_reg) begin
      pin_next = divClk_reg;
    end else begin
      pin_next = (pulseCnt_next == '0);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pulseCnt_reg <= '0;
      divClk_reg   <= 1'b0;
      pin_reg      <= 1'b1;
    end else begin
      pulseCnt_reg <= pulseCnt_next;
      divClk_reg   <= !divClk_reg;
      pin_reg      <= pin_next;
    end
  end

  assign clockOrReadyOutPin = pin_reg;
  assign inputShortEnable   = shortSel_reg;

  // ==========================================================================
  // Interrupt
  logic irq_reg;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= status_next.initDone ||
                 (status_next.convReady && mask_next.convReady);
    end
  end

  assign irq  = irq_reg;
  assign irqN = !irq_reg;

endmodule

`default_nettype wire

// *** dv/ais_init_seq_checker.sv ***
/* Port checker of the power-up sequencer, bound into ais_init_seq.
   Assumes no sample strobe is given while clock-out mode is on. */
`default_nettype none

module ais_init_seq_checker #(
  parameter logic [ais_pkg::DELAY_W-1:0] INIT_DONE_CYCLES = 24'h000014,
  parameter logic [ais_pkg::DELAY_W-1:0] ISO_READY_CYCLES = 24'h000028
) (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sampleStrobe,
  input wire logic        clockOrReadyOutPin,
  input wire logic        inputShortEnable,
  input wire logic        irq,
  input wire logic        irqN
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int IRQ_WIN = INIT_DONE_CYCLES + 4;
  localparam int ISO_LIM = ISO_READY_CYCLES + 4;
  logic [15:0] lowCnt_reg;
  logic [15:0] lowCnt_next;
  logic [23:0] upCnt_reg;
  logic [23:0] upCnt_next;
  logic        softWr;

  // ==========
  // Pin low time and time since start, restarted by a soft reset
  always_comb begin
    softWr = wb_ack_o && wb_we_i && wb_sel_i[0]
      && wb_dat_i[ais_pkg::SOFT_RESET_BIT]
      && wb_adr_i == ais_pkg::DEVICE_CONFIG_OFS;
    lowCnt_next = clockOrReadyOutPin ? 16'h0000 : lowCnt_reg + 16'h0001;
    upCnt_next = softWr ? 24'h000000 : upCnt_reg + 24'h000001;
    if (!rstn) begin
      lowCnt_next = 16'h0000;
      upCnt_next = 24'h000000;
    end
  end

  always_ff @(posedge clock) begin
    lowCnt_reg <= lowCnt_next;
    upCnt_reg <= upCnt_next;
  end

  // ==========
  // Assertions
  ack_one_cycle_a: assert property (@(posedge clock) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_follows_req_a: assert property (@(posedge clock) disable iff (!rstn)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  read_upper_zero_a: assert property (@(posedge clock) disable iff (!rstn)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read data not zero");
  irq_pin_inverse_a: assert property (
    @(posedge clock) disable iff (!rstn) irqN != irq)
    else $error("interrupt pin not inverse of irq");
  pin_reset_high_a: assert property (
    @(posedge clock) disable iff (!rstn) $rose(rstn) |-> clockOrReadyOutPin)
    else $error("ready pin not idle high after reset");
  init_irq_a: assert property (
    @(posedge clock) disable iff (!rstn)
    $rose(rstn) |-> (!irq) [*8] ##[1:IRQ_WIN] irq)
    else $error("init done interrupt not on time");
  strobe_pin_low_a: assert property (
    @(posedge clock) disable iff (!rstn)
    sampleStrobe && upCnt_reg > ISO_LIM |=> !clockOrReadyOutPin)
    else $error("accepted strobe did not pull pin low");
  pulse_length_a: assert property (
    @(posedge clock) disable iff (!rstn) $rose(clockOrReadyOutPin) |->
    lowCnt_reg == 16'h0001 || lowCnt_reg >= ais_pkg::READY_PULSE_CYCLES)
    else $error("ready pulse too short");
endmodule

bind ais_init_seq ais_init_seq_checker #(
  .INIT_DONE_CYCLES(INIT_DONE_CYCLES), .ISO_READY_CYCLES(ISO_READY_CYCLES)
) chk (
  .clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sampleStrobe(sampleStrobe), .clockOrReadyOutPin(clockOrReadyOutPin),
  .inputShortEnable(inputShortEnable), .irq(irq), .irqN(irqN)
);

`default_nettype wire

// *** dv/ais_host_model.sv ***
/* Host side of the sample-ready pin: counts falling edges and measures
   each low time in clocks. Assumes the pin idles high. */
`default_nettype none

module ais_host_model (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        readyPin,
  output var  logic [15:0] pulseCount,
  output var  logic [15:0] lowLength
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        pinLast;
  logic [15:0] lowRun;

  always @(posedge clock) begin
    pinLast <= readyPin;
    if (!rstn) begin
      pulseCount <= 16'h0000;
      lowRun <= 16'h0000;
      lowLength <= 16'h0000;
    end else begin
      if (pinLast && !readyPin) begin
        pulseCount <= pulseCount + 16'h0001;
      end
      if (!readyPin) begin
        lowRun <= lowRun + 16'h0001;
      end else if (lowRun != 16'h0000) begin
        lowLength <= lowRun;
        lowRun <= 16'h0000;
      end
    end
  end
endmodule

`default_nettype wire

// *** dv/ais_init_seq_test.sv ***
/* Self-checking bench of the power-up sequencer.
   Assumes the checker binds itself and the host model watches the pin. */
`default_nettype none

module ais_init_seq_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0]  PST = ais_pkg::PRIMARY_STATUS_OFS;
  localparam logic [7:0]  MSK = ais_pkg::INT_MASK_OFS;
  localparam logic [7:0]  SST = ais_pkg::SECONDARY_STATUS_OFS;
  localparam logic [7:0]  CFG = ais_pkg::DEVICE_CONFIG_OFS;
  localparam logic [7:0]  LCK = ais_pkg::CONFIG_LOCK_OFS;
  localparam logic [7:0]  ISA = ais_pkg::ISO_ACCESS_OFS;
  localparam logic [7:0]  SHT = ais_pkg::INPUT_SHORT_OFS;
  localparam logic [23:0] INIT_C = 24'h000014;
  localparam logic [23:0] ISO_C = 24'h000028;
  logic        clock = 1'b0;
  logic        rstn, wbCyc, wbStb, wbWe, wbAck, strobe;
  logic        pin, shortEn, irq, irqN;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel, selUse;
  logic [31:0] wbDatI, wbDatO;
  logic [15:0] pulseCount, lowLength;
  int          cycles = 0;
  int          rel, fail_count = 0, checks = 0;

  ais_init_seq #(.INIT_DONE_CYCLES(INIT_C), .ISO_READY_CYCLES(ISO_C)) uut (
    .clock(clock), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .sampleStrobe(strobe),
    .clockOrReadyOutPin(pin), .inputShortEnable(shortEn), .irq(irq),
    .irqN(irqN));
  ais_host_model host (.clock(clock), .rstn(rstn), .readyPin(pin),
    .pulseCount(pulseCount), .lowLength(lowLength));

  always #2 clock = ~clock;

  // ==========
  // Shared tasks
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbSel <= selUse;
    wbDatI <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wbAck !== 1'b1);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    check(n, 32'h00000002);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    check(q, e);
  endtask

  task automatic poll(input logic [7:0] a, input int b);
    logic [31:0] q;
    do begin
      bus(1'b0, a, 32'h00000000, q);
    end while (q[b] !== 1'b1);
  endtask

  task automatic fire();
    @(posedge clock);
    strobe <= 1'b1;
    @(posedge clock);
    strobe <= 1'b0;
    #1;
  endtask

  task automatic settle();
    while (pin !== 1'b1) begin
      @(posedge clock);
    end
    repeat (2) @(posedge clock);
  endtask

  // ==========
  // Scenarios
  task automatic t_reset();
    fire();
    check(pin, 1'b1);
    for (int i = 0; i < 8; i++) begin
      rdc(8'(i * 4), 32'h00000000);
    end
  endtask

  task automatic t_init();
    poll(PST, ais_pkg::INIT_DONE_BIT);
    check(cycles - rel > INIT_C, 1'b1);
    check(irq, 1'b1);
    check(irqN, 1'b0);
    wr(PST, 32'h00000020);
    rdc(PST, 32'h00000000);
    check(irq, 1'b0);
  endtask

  task automatic t_conv();
    logic [15:0] p;
    poll(SST, ais_pkg::ISO_READY_BIT);
    check(cycles - rel > ISO_C, 1'b1);
    wr(MSK, 32'h00000010);
    p = pulseCount;
    fire();
    check(pin, 1'b0);
    check(irq, 1'b1);
    rdc(PST, 32'h00000010);
    rdc(SST, 32'h00000001);
    settle();
    check(lowLength, ais_pkg::READY_PULSE_CYCLES);
    check(pulseCount - p, 16'h0001);
    wr(MSK, 32'h00000000);
    wr(PST, 32'h00000010);
    fire();
    check(irq, 1'b0);
    rdc(PST, 32'h00000010);
    wr(PST, 32'h00000010);
    settle();
  endtask

  task automatic t_lock();
    logic a;
    wr(CFG, 32'h00000001);
    repeat (2) @(posedge clock);
    #1;
    a = pin;
    @(posedge clock);
    #1;
    check(pin, !a);
    selUse = 4'he;
    wr(CFG, 32'h00000000);
    selUse = 4'hf;
    rdc(CFG, 32'h00000001);
    wr(LCK, {24'h000000, ais_pkg::LOCK_KEY});
    rdc(LCK, 32'h00000001);
    rdc(SST, 32'h00000003);
    wr(CFG, 32'h00000000);
    rdc(CFG, 32'h00000001);
  endtask

  task automatic t_short();
    wr(SHT, 32'h00000001);
    rdc(SHT, 32'h00000000);
    check(shortEn, 1'b0);
    wr(ISA, 32'h00000001);
    wr(SHT, 32'h00000001);
    rdc(SHT, 32'h00000001);
    check(shortEn, 1'b1);
    repeat (8) @(posedge clock);
    rdc(SST, 32'h00000007);
    wr(SHT, 32'h00000000);
    repeat (8) @(posedge clock);
    wr(ISA, 32'h00000000);
    rdc(ISA, 32'h00000000);
    check(shortEn, 1'b0);
  endtask

  task automatic t_soft();
    wr(CFG, 32'h00000002);
    rel = cycles;
    rdc(LCK, 32'h00000000);
    rdc(SST, 32'h00000000);
    check(pin, 1'b1);
    poll(PST, ais_pkg::INIT_DONE_BIT);
    check(cycles - rel > INIT_C, 1'b1);
    check(cycles - rel < INIT_C + 8, 1'b1);
  endtask

  initial begin
    rstn = 1'b0;
    strobe = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'hf;
    selUse = 4'hf;
    wbDatI = 32'h00000000;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    rel = cycles;
    t_reset();
    t_init();
    t_conv();
    t_lock();
    t_short();
    t_soft();
    give_verdict();
  end
endmodule

`default_nettype wire
